/* ncoa_align.sv */
// NCO phase alignment controller: registers, trigger selection, status and interrupt
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Mode field picks trigger: 00 off, 10 data key, 01 SYSREF.
// - Match status bit 5 reads 1 when alignment came from a data match.
// - Finished attempt without data-match alignment leaves match bit at 0.
// - Pass status bit 4 reads 1 once alignment took effect on phase.
// - Pass bit reads 0 while an armed alignment is still pending.
// - Fail bit 3 reads 1 if NCO reset while rotating; 0 until finished.
// - Sixteen-bit writable I key held as low and high byte registers.
// - Sixteen-bit writable Q key held as low and high byte registers.
// - Software arms by taking bit 7 from 0 to 1; only that edge starts.
module ncoa_align
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Incoming I/Q sample path
  input wire logic smp_valid,
  input wire logic [15:0] smp_i,
  input wire logic [15:0] smp_q,
  // Qualified SYSREF event
  input wire logic sysref_event,
  // NCO phase accumulators
  input wire logic nco_rotating,
  output logic nco_phase_reset,
  // Interrupt
  output logic irq
);

  // ==========================================================================
  // Address decode
  // ==========================================================================
  function automatic logic hit_addr(input logic [7:0] addr, input logic [7:0] ofs);
    hit_addr = (addr == ofs);
  endfunction

  logic wr_ctrl;
  logic wr_irq_status;
  logic wr_irq_mask;
  assign wr_ctrl = reg_wr && hit_addr(reg_addr, ncoa_pkg::OFS_CTRL_STATUS);
  assign wr_irq_status = reg_wr && hit_addr(reg_addr, ncoa_pkg::OFS_IRQ_STATUS);
  assign wr_irq_mask = reg_wr && hit_addr(reg_addr, ncoa_pkg::OFS_IRQ_MASK);

  // ==========================================================================
  // Key registers
  // ==========================================================================
  logic [7:0] key_i_low_q;
  logic [7:0] key_i_high_q;
  logic [7:0] key_q_low_q;
  logic [7:0] key_q_high_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      key_i_low_q <= ncoa_pkg::RST_BYTE;
      key_i_high_q <= ncoa_pkg::RST_BYTE;
      key_q_low_q <= ncoa_pkg::RST_BYTE;
      key_q_high_q <= ncoa_pkg::RST_BYTE;
    end
    else if (reg_wr)
    begin
      if (hit_addr(reg_addr, ncoa_pkg::OFS_KEY_I_LOW))
      begin
        key_i_low_q <= reg_wdata;
      end
      if (hit_addr(reg_addr, ncoa_pkg::OFS_KEY_I_HIGH))
      begin
        key_i_high_q <= reg_wdata;
      end
      if (hit_addr(reg_addr, ncoa_pkg::OFS_KEY_Q_LOW))
      begin
        key_q_low_q <= reg_wdata;
      end
      if (hit_addr(reg_addr, ncoa_pkg::OFS_KEY_Q_HIGH))
      begin
        key_q_high_q <= reg_wdata;
      end
    end
  end

  // ==========================================================================
  // Control fields
  // ==========================================================================
  logic arm_q;
  logic [1:0] mode_q;
  logic arm_rise;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      arm_q <= 1'b0;
      mode_q <= ncoa_pkg::RST_MODE;
    end
    else if (wr_ctrl)
    begin
      arm_q <= reg_wdata[ncoa_pkg::BIT_ARM];
      mode_q <= reg_wdata[ncoa_pkg::MODE_LSB +: ncoa_pkg::MODE_W];
    end
  end

  // Only a 0 to 1 write starts; rewriting a 1 does nothing
  assign arm_rise = wr_ctrl && reg_wdata[ncoa_pkg::BIT_ARM] && !arm_q;

  // ==========================================================================
  // Comparator
  // ==========================================================================
  ncoa_pkg::ncoa_state_t state_q;
  logic [1:0] run_mode_q;
  ncoa_cmp_if cmp_bus ();

  assign cmp_bus.key_i = {key_i_high_q, key_i_low_q};
  assign cmp_bus.key_q = {key_q_high_q, key_q_low_q};
  assign cmp_bus.smp_i = smp_i;
  assign cmp_bus.smp_q = smp_q;
  assign cmp_bus.smp_valid = smp_valid;
  assign cmp_bus.enable = (state_q == ncoa_pkg::ST_WAIT_TRIG) && (run_mode_q == ncoa_pkg::MODE_DATA_KEY);

  ncoa_key_cmp u_cmp
  (
    .clk(clk),
    .resetn(resetn),
    .cmp(cmp_bus.cmp)
  );

  // ==========================================================================
  // Trigger selection
  // ==========================================================================
  logic trig;
  logic [1:0] arm_mode;

  // Mode 11 is undefined and treated as disabled
  assign arm_mode = wr_ctrl ? reg_wdata[ncoa_pkg::MODE_LSB +: ncoa_pkg::MODE_W] : mode_q;

  always_comb
  begin
    trig = 1'b0;
    if (state_q == ncoa_pkg::ST_WAIT_TRIG)
    begin
      unique case (run_mode_q)
        ncoa_pkg::MODE_DATA_KEY: trig = cmp_bus.hit;
        ncoa_pkg::MODE_SYSREF: trig = sysref_event;
        default: trig = 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // Alignment sequence
  // ==========================================================================
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ncoa_pkg::ST_IDLE;
      run_mode_q <= ncoa_pkg::RST_MODE;
    end
    else
    begin
      unique case (state_q)
        ncoa_pkg::ST_IDLE, ncoa_pkg::ST_DONE:
        begin
          if (arm_rise && (arm_mode == ncoa_pkg::MODE_DATA_KEY || arm_mode == ncoa_pkg::MODE_SYSREF))
          begin
            state_q <= ncoa_pkg::ST_WAIT_TRIG;
            run_mode_q <= arm_mode;
          end
        end
        ncoa_pkg::ST_WAIT_TRIG:
        begin
          // A new arming edge restarts the wait in the newly written mode, or returns to idle if that mode is off or 11
          if (arm_rise)
          begin
            run_mode_q <= arm_mode;
            if (arm_mode != ncoa_pkg::MODE_DATA_KEY && arm_mode != ncoa_pkg::MODE_SYSREF)
            begin
              state_q <= ncoa_pkg::ST_IDLE;
            end
          end
          else if (trig)
          begin
            state_q <= ncoa_pkg::ST_DONE;
          end
        end
        default:
        begin
          state_q <= ncoa_pkg::ST_IDLE;
        end
      endcase
    end
  end

  logic fire;
  assign fire = (state_q == ncoa_pkg::ST_WAIT_TRIG) && !arm_rise && trig;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      nco_phase_reset <= 1'b0;
    end
    else
    begin
      nco_phase_reset <= fire;
    end
  end

  // ==========================================================================
  // Status bits
  // ==========================================================================
  logic match_q;
  logic pass_q;
  logic fail_q;

  // The phase reset takes effect on the edge where it is issued, so status follows the same edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      match_q <= 1'b0;
      pass_q <= 1'b0;
      fail_q <= 1'b0;
    end
    else if (arm_rise)
    begin
      match_q <= 1'b0;
      pass_q <= 1'b0;
      fail_q <= 1'b0;
    end
    else if (fire)
    begin
      match_q <= (run_mode_q == ncoa_pkg::MODE_DATA_KEY) && !nco_rotating;
      pass_q <= !nco_rotating;
      fail_q <= nco_rotating;
    end
  end

  // ==========================================================================
  // Interrupts
  // ==========================================================================
  logic [2:0] irq_status_q;
  logic [2:0] irq_mask_q;
  logic [2:0] irq_event;
  logic [2:0] irq_status_d;

  assign irq_event[ncoa_pkg::IRQ_DONE] = fire;
  assign irq_event[ncoa_pkg::IRQ_FAIL] = fire && nco_rotating;
  assign irq_event[ncoa_pkg::IRQ_MATCH] = fire && !nco_rotating && (run_mode_q == ncoa_pkg::MODE_DATA_KEY);

  // A set in the same cycle as a write-one-to-clear wins, so no event is lost
  generate
    for (genvar g = 0; g < ncoa_pkg::IRQ_W; g++)
    begin : g_irq
      assign irq_status_d[g] = irq_event[g] || (irq_status_q[g] && !(wr_irq_status && reg_wdata[g]));
    end
  endgenerate

  // One process owns the whole status word, so no bit has a second writer
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_status_q <= ncoa_pkg::RST_IRQ;
    end
    else
    begin
      irq_status_q <= irq_status_d;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_mask_q <= ncoa_pkg::RST_IRQ;
    end
    else if (wr_irq_mask)
    begin
      irq_mask_q <= reg_wdata[ncoa_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // ==========================================================================
  // Read back
  // ==========================================================================
  logic [7:0] ctrl_rd;

  always_comb
  begin
    ctrl_rd = 8'h00;
    ctrl_rd[ncoa_pkg::BIT_ARM] = arm_q;
    ctrl_rd[ncoa_pkg::BIT_MATCH] = match_q;
    ctrl_rd[ncoa_pkg::BIT_PASS] = pass_q;
    ctrl_rd[ncoa_pkg::BIT_FAIL] = fail_q;
    ctrl_rd[ncoa_pkg::MODE_LSB +: ncoa_pkg::MODE_W] = mode_q;
  end

  // Data stand only in the cycle after the read strobe; unmapped addresses read zero
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata <= 8'h00;
    end
    else if (!reg_rd)
    begin
      reg_rdata <= 8'h00;
    end
    else
    begin
      case (reg_addr)
        ncoa_pkg::OFS_CTRL_STATUS: reg_rdata <= ctrl_rd;
        ncoa_pkg::OFS_KEY_I_LOW: reg_rdata <= key_i_low_q;
        ncoa_pkg::OFS_KEY_I_HIGH: reg_rdata <= key_i_high_q;
        ncoa_pkg::OFS_KEY_Q_LOW: reg_rdata <= key_q_low_q;
        ncoa_pkg::OFS_KEY_Q_HIGH: reg_rdata <= key_q_high_q;
        ncoa_pkg::OFS_IRQ_STATUS: reg_rdata <= {5'h00, irq_status_q};
        ncoa_pkg::OFS_IRQ_MASK: reg_rdata <= {5'h00, irq_mask_q};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule // ncoa_align
`default_nettype wire

/* ncoa_align_sva.sv */
// Checker for the NCO phase alignment block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module ncoa_align_chk
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Sample path and timing
  input wire logic smp_valid,
  input wire logic [15:0] smp_i,
  input wire logic [15:0] smp_q,
  input wire logic sysref_event,
  // NCO and interrupt
  input wire logic nco_rotating,
  input wire logic nco_phase_reset,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Follows the arm bit and the end of each attempt, so a status read can be judged
  logic arm_seen_q;
  logic fin_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      arm_seen_q <= 1'b0;
    end
    else if (reg_wr && reg_addr == 8'h50)
    begin
      arm_seen_q <= reg_wdata[7];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fin_q <= 1'b0;
    end
    else if (reg_wr && reg_addr == 8'h50 && reg_wdata[7] && !arm_seen_q)
    begin
      fin_q <= 1'b0;
    end
    else if (nco_phase_reset)
    begin
      fin_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Register port
  // ==========================================================================
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  chk_reserved_zero: assert property (reg_rd && reg_addr == 8'h50 |=> !reg_rdata[6] && !reg_rdata[2])
    else $error("reserved control bits not zero");
  chk_unmapped_zero: assert property (reg_rd && reg_addr > 8'h5F |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // ==========================================================================
  // Alignment outcome
  // ==========================================================================
  chk_phase_cause: assert property (nco_phase_reset |-> $past(sysref_event) || $past(smp_valid, 2))
    else $error("phase reset without trigger");
  chk_phase_pulse: assert property (nco_phase_reset |=> !nco_phase_reset)
    else $error("phase reset longer than one cycle");
  chk_status_outcome: assert property (reg_rd && reg_addr == 8'h50 && fin_q |=> reg_rdata[4] != reg_rdata[3])
    else $error("finished attempt lacks single pass or fail");
  chk_match_pass: assert property (reg_rd && reg_addr == 8'h50 |=> !reg_rdata[5] || reg_rdata[4])
    else $error("match set without pass");
  chk_irq_masked: assert property (reg_wr && reg_addr == 8'h5F && reg_wdata == 8'h00 |=> !irq)
    else $error("irq high with all sources masked");
endmodule // ncoa_align_chk

bind ncoa_align ncoa_align_chk ncoa_align_chk_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .smp_valid(smp_valid),
  .smp_i(smp_i), .smp_q(smp_q), .sysref_event(sysref_event), .nco_rotating(nco_rotating),
  .nco_phase_reset(nco_phase_reset), .irq(irq));
`default_nettype wire

/* ncoa_cmp_if.sv */
// Interface that carries keys, samples and the match result between the controller and the comparator
`timescale 1ns/1ps
`default_nettype none
interface ncoa_cmp_if;
  logic [ncoa_pkg::KEY_W-1:0] key_i;
  logic [ncoa_pkg::KEY_W-1:0] key_q;
  logic [ncoa_pkg::KEY_W-1:0] smp_i;
  logic [ncoa_pkg::KEY_W-1:0] smp_q;
  logic smp_valid;
  logic enable;
  logic hit;

  modport ctl (output key_i, output key_q, output smp_i, output smp_q, output smp_valid, output enable, input hit);
  modport cmp (input key_i, input key_q, input smp_i, input smp_q, input smp_valid, input enable, output hit);
endinterface
`default_nettype wire

/* ncoa_key_cmp.sv */
// Sample pair comparator against the programmed I and Q keys
`timescale 1ns/1ps
`default_nettype none
module ncoa_key_cmp
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Keys, samples and result
  ncoa_cmp_if.cmp cmp
);

  // ==========================================================================
  // Compare
  // ==========================================================================
  // Registered so the trigger path sees a clean flop, at the cost of one cycle of latency
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmp.hit <= 1'b0;
    end
    else
    begin
      cmp.hit <= cmp.enable && cmp.smp_valid && (cmp.smp_i == cmp.key_i) && (cmp.smp_q == cmp.key_q);
    end
  end

endmodule // ncoa_key_cmp
`default_nettype wire

/* ncoa_pkg.sv */
// Package with register map, field positions, reset values and state types of the NCO phase alignment block
package ncoa_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int KEY_W = 16;

  localparam logic [7:0] OFS_CTRL_STATUS = 8'h50;
  localparam logic [7:0] OFS_KEY_I_LOW = 8'h51;
  localparam logic [7:0] OFS_KEY_I_HIGH = 8'h52;
  localparam logic [7:0] OFS_KEY_Q_LOW = 8'h53;
  localparam logic [7:0] OFS_KEY_Q_HIGH = 8'h54;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h5E;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h5F;

  // ==========================================================================
  // Control and status fields
  // ==========================================================================
  localparam int BIT_ARM = 7;
  localparam int BIT_MATCH = 5;
  localparam int BIT_PASS = 4;
  localparam int BIT_FAIL = 3;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 2;

  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SYSREF = 2'h1;
  localparam logic [1:0] MODE_DATA_KEY = 2'h2;

  // Interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_MATCH = 2;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [2:0] RST_IRQ = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_TRIG,
    ST_DONE
  } ncoa_state_t;

endpackage

/* ncoa_src_model.sv */
// Model of the incoming sample path and SYSREF timing source
`timescale 1ns/1ps
`default_nettype none
module ncoa_src_model
(
  // Clock
  input wire logic clk,
  // Sample path
  output logic smp_valid,
  output logic [15:0] smp_i,
  output logic [15:0] smp_q,
  // Timing and NCO state
  output logic sysref_event,
  output logic nco_rotating
);
  logic [15:0] vi = 16'h0000;
  logic [15:0] vq = 16'h0000;
  logic tog = 1'b0;

  initial
  begin
    smp_valid = 1'b0;
    sysref_event = 1'b0;
    nco_rotating = 1'b0;
  end

  always @(posedge clk) tog <= ~tog;
  // Lanes churn outside valid beats so a held value is never trusted
  assign smp_i = smp_valid ? vi : ~vi ^ {16{tog}};
  assign smp_q = smp_valid ? vq : ~vq ^ {16{tog}};

  task automatic send(input logic [15:0] i, input logic [15:0] q);
    @(posedge clk);
    smp_valid <= 1'b1;
    vi <= i;
    vq <= q;
    @(posedge clk);
    smp_valid <= 1'b0;
  endtask

  task automatic sysref(input logic rot);
    @(posedge clk);
    sysref_event <= 1'b1;
    nco_rotating <= rot;
    @(posedge clk);
    sysref_event <= 1'b0;
    nco_rotating <= 1'b0;
  endtask
endmodule // ncoa_src_model
`default_nettype wire

/* test_nco_phase_align.sv */
// Self-checking testbench for the NCO phase alignment block
`timescale 1ns/1ps
`default_nettype none
module test_nco_phase_align;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic smp_valid, sysref_event, nco_rotating, nco_phase_reset, irq;
  logic [15:0] smp_i, smp_q;
  int num_errors = 0;
  int checks = 0;
  int pulses = 0;

  always #12.5 clk = ~clk;
  always @(posedge clk) if (nco_phase_reset === 1'b1) pulses++;

  ncoa_align ncoa_align_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .smp_valid(smp_valid), .smp_i(smp_i),
    .smp_q(smp_q), .sysref_event(sysref_event), .nco_rotating(nco_rotating),
    .nco_phase_reset(nco_phase_reset), .irq(irq));
  ncoa_src_model ncoa_src_model_i (.clk(clk), .smp_valid(smp_valid), .smp_i(smp_i), .smp_q(smp_q),
    .sysref_event(sysref_event), .nco_rotating(nco_rotating));

  // ==========================================================================
  // Bus and compare helpers
  // ==========================================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, what);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs();
    logic [7:0] adr [7] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h5E, 8'h5F};
    foreach (adr[k]) rd(adr[k], 8'h00, "reset value");
    wr(8'h51, 8'h34);
    wr(8'h52, 8'h12);
    wr(8'h53, 8'hCD);
    wr(8'h54, 8'hAB);
    rd(8'h51, 8'h34, "key i low");
    rd(8'h52, 8'h12, "key i high");
    rd(8'h53, 8'hCD, "key q low");
    rd(8'h54, 8'hAB, "key q high");
    wr(8'h50, 8'h38);
    rd(8'h50, 8'h00, "status bits read only");
    wr(8'h70, 8'hFF);
    rd(8'h70, 8'h00, "unmapped");
  endtask

  task automatic t_sysref(input logic rot);
    int p0;
    wr(8'h5F, 8'h07);
    wr(8'h50, 8'h01);
    wr(8'h50, 8'h81);
    rd(8'h50, 8'h81, "armed on sysref");
    p0 = pulses;
    ncoa_src_model_i.sysref(rot);
    repeat (3) @(posedge clk);
    chk(8'(pulses - p0), 8'h01, "sysref phase reset");
    rd(8'h50, rot ? 8'h89 : 8'h91, "sysref outcome");
    chk({7'h00, irq}, 8'h01, "irq raised");
    rd(8'h5E, rot ? 8'h03 : 8'h01, "irq status");
    wr(8'h5E, 8'h07);
    #1;
    chk({7'h00, irq}, 8'h00, "irq cleared");
  endtask

  task automatic t_datakey();
    int p0;
    wr(8'h50, 8'h02);
    wr(8'h50, 8'h82);
    p0 = pulses;
    ncoa_src_model_i.send(16'h1234, 16'hABCC);
    ncoa_src_model_i.send(16'hABCD, 16'h1234);
    repeat (3) @(posedge clk);
    rd(8'h50, 8'h82, "no match yet");
    ncoa_src_model_i.send(16'h1234, 16'hABCD);
    ncoa_src_model_i.send(16'h1234, 16'hABCD);
    repeat (3) @(posedge clk);
    chk(8'(pulses - p0), 8'h01, "first match only");
    rd(8'h50, 8'hB2, "data match outcome");
    rd(8'h5E, 8'h05, "irq status");
    wr(8'h5F, 8'h00);
    #1;
    chk({7'h00, irq}, 8'h00, "irq masked");
    wr(8'h5E, 8'h07);
  endtask

  task automatic t_off();
    int p0;
    wr(8'h50, 8'h00);
    wr(8'h50, 8'h80);
    p0 = pulses;
    ncoa_src_model_i.sysref(1'b0);
    ncoa_src_model_i.send(16'h1234, 16'hABCD);
    // Arm bit already set: no new attempt may start
    wr(8'h50, 8'h81);
    ncoa_src_model_i.sysref(1'b0);
    repeat (3) @(posedge clk);
    chk(8'(pulses - p0), 8'h00, "no trigger taken");
    rd(8'h50, 8'h81, "not started");
    // Undefined mode 11 must behave as disabled
    wr(8'h50, 8'h03);
    wr(8'h50, 8'h83);
    ncoa_src_model_i.sysref(1'b0);
    ncoa_src_model_i.send(16'h1234, 16'hABCD);
    repeat (3) @(posedge clk);
    chk(8'(pulses - p0), 8'h00, "mode 11 inert");
    rd(8'h50, 8'h83, "mode 11 not started");
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_sysref(1'b0);
    t_sysref(1'b1);
    t_datakey();
    t_off();
    end_sim();
  end

  initial
  begin
    repeat (3000) @(posedge clk);
    num_errors++;
    end_sim();
  end
endmodule // test_nco_phase_align
`default_nettype wire
